// ==== baud_pkg.sv ====
// constants and configuration carrier for the baud rate generator
package baud_pkg;

  // ********************************************************************
  // divider source select encodings
  // ********************************************************************
  localparam logic [1:0] SRC_MCLK     = 2'h0; // master_clock itself
  localparam logic [1:0] SRC_MCLK_DIV = 2'h1; // master_clock over eight
  localparam logic [1:0] SRC_EXT      = 2'h3; // external serial clock pin

  // ********************************************************************
  // counter limits
  // ********************************************************************
  localparam logic [2:0]  PRESCALE_LAST = 3'h7;    // fixed divide by 8
  localparam logic [3:0]  OS16_LAST     = 4'hF;    // 16x oversampling
  localparam logic [3:0]  OS8_LAST      = 4'h7;    // 8x oversampling
  localparam logic [15:0] DIV_OFF       = 16'h0000; // no clock except pin edges in sync external mode
  localparam logic [15:0] DIV_BYPASS    = 16'h0001; // divider bypassed
  localparam logic [15:0] DIV_ONE       = 16'h0001; // unit step

  // ********************************************************************
  // configuration carrier (channel_mode_register / baud_divider_register)
  // ********************************************************************
  typedef struct packed {
    logic [1:0]  divider_source_select; // clock source
    logic        sync_mode;             // 1 = synchronous
    logic        over8;                 // 1 = 8x, 0 = 16x oversampling
    logic        normal_mode;           // channel in normal mode
    logic [15:0] clock_divisor;         // integer divisor
    logic [2:0]  fraction_eighths;      // fractional part in eighths
  } baud_cfg_t;

endpackage

// ==== baud_gen.sv ====
// baud rate generator: source select, divider, fraction, oversampling
`timescale 1ns/1ps

// ********************************************************************
// baud rate generator
// ********************************************************************
// Notes on behaviour
// (RULE1) source is master_clock, master_clock over eight, or external pin
// (RULE2) a 16-bit integer divider counts source ticks by clock_divisor
// (RULE3) clock_divisor zero stops every baud and sampling tick except in sync mode with the external pin source
// (RULE4) clock_divisor one passes the selected source through undivided
// (RULE5) external clock phases exceed one master period, rate 4.5x slower
// (RULE6) async: divided clock is sampling tick, then divided by 16 or 8
// (RULE7) over8 set samples at 8x baud, cleared samples at 16x
// (RULE8) async rate is source over 8 times (2 - over8) times divisor
// (RULE9) nonzero fraction_eighths enables fractional division in eighths
// (RULE10) fraction adds eighths to the divisor, only async normal mode
// (RULE11) sync: baud is the source divided by divisor, no oversampling
// (RULE12) sync with external source: pin edge is the bit clock directly
// (RULE13) master_clock source gives 50:50 serial clock even for odd divisor; divisor one leaves sck_out low
// (RULE14) software wanting 50:50 with divided source programs even divisor
// (RULE15) software keeps the baud rate error at or below five percent
// (RULE16) external clock synchronised; ticks are one-cycle enable pulses
module baud_gen
  import baud_pkg::*;
(
  input  logic      mclk,        // master clock, 20 MHz
  input  logic      rst,         // synchronous reset, active high
  input  baud_cfg_t cfg,         // mode and divider configuration
  input  logic      sck_in,      // serial clock pin, input side
  output logic      sample_tick, // receiver sampling enable pulse
  output logic      baud_tick,   // bit period enable pulse
  output logic      sck_out,     // serial clock pin, output side
  output logic      sck_oe       // serial clock pin drive enable
);

  logic        meta_q;
  logic        sync_q;
  logic        chk_q;
  logic        lvl_q;
  logic        lvl_new;
  logic        ext_tick;
  logic [2:0]  pre_q;
  logic        pre_tick;
  logic        src_tick;
  logic        frac_on;
  logic        ext_direct;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] limit;
  logic        div_tick;
  logic [2:0]  acc_q;
  logic        extra_q;
  logic [3:0]  os_q;
  logic [3:0]  os_last;
  logic        os_tick;
  logic        sample_q;
  logic        baud_q;
  logic        hi_q;
  logic        hi_n_q;
  logic        odd_fix;

  // ********************************************************************
  // external clock synchroniser
  // ********************************************************************
  // three stages; a level counts only once stages two and three agree,
  // which relies on the pin phases outlasting a master period [RULE5]
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      chk_q  <= 1'b0;
      lvl_q  <= 1'b0;
    end else begin
      meta_q <= sck_in;
      sync_q <= meta_q;
      chk_q  <= sync_q;
      lvl_q  <= lvl_new;
    end
  end

  assign lvl_new  = (sync_q == chk_q) ? chk_q : lvl_q;
  assign ext_tick = lvl_new & ~lvl_q; // rising edge pulse [RULE16]

  // ********************************************************************
  // fixed prescaler and source select
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 3'h1;
    end
  end

  assign pre_tick = (pre_q == PRESCALE_LAST);

  always_comb begin
    case (cfg.divider_source_select)
      SRC_MCLK:     src_tick = 1'b1;     // [RULE1]
      SRC_MCLK_DIV: src_tick = pre_tick; // [RULE1]
      default:      src_tick = ext_tick; // [RULE1]
    endcase
  end

  // ********************************************************************
  // integer divider with fractional stretch
  // ********************************************************************
  assign frac_on    = (cfg.fraction_eighths != 3'h0) & ~cfg.sync_mode
                      & cfg.normal_mode; // [RULE9] [RULE10]
  assign ext_direct = cfg.sync_mode &
                      (cfg.divider_source_select == SRC_EXT); // [RULE12]
  assign limit      = cfg.clock_divisor - DIV_ONE + {15'h0000, extra_q};

  // terminal test uses >= so a shrinking divisor never wraps the counter
  always_comb begin
    if (cfg.clock_divisor == DIV_OFF) begin
      div_tick = 1'b0;     // [RULE3]
    end else if (cfg.clock_divisor == DIV_BYPASS) begin
      div_tick = src_tick; // [RULE4]
    end else begin
      div_tick = src_tick & (cnt_q >= limit); // [RULE2]
    end
  end

  always_comb begin
    if (cfg.clock_divisor <= DIV_BYPASS) begin
      cnt_d = 16'h0000;
    end else if (div_tick) begin
      cnt_d = 16'h0000;
    end else if (src_tick) begin
      cnt_d = cnt_q + DIV_ONE; // [RULE2]
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // each period is divisor or divisor+1 long; eight periods average
  // divisor + fraction/8, jitter of one source tick traded for resolution
  always_ff @(posedge mclk) begin
    if (rst || !frac_on) begin
      acc_q   <= 3'h0;
      extra_q <= 1'b0;
    end else if (div_tick) begin
      {extra_q, acc_q} <= {1'b0, acc_q}
                          + {1'b0, cfg.fraction_eighths}; // [RULE10]
    end
  end

  // ********************************************************************
  // oversampling divider
  // ********************************************************************
  assign os_last = cfg.over8 ? OS8_LAST : OS16_LAST; // [RULE7]
  assign os_tick = div_tick & (os_q >= os_last);     // [RULE6] [RULE8]

  always_ff @(posedge mclk) begin
    if (rst || cfg.sync_mode) begin
      os_q <= 4'h0;
    end else if (div_tick) begin
      os_q <= (os_q >= os_last) ? 4'h0 : os_q + 4'h1; // [RULE6]
    end
  end

  // ********************************************************************
  // tick outputs
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_q <= 1'b0;
      baud_q   <= 1'b0;
    end else if (ext_direct) begin
      sample_q <= ext_tick; // [RULE12]
      baud_q   <= ext_tick; // [RULE12]
    end else begin
      sample_q <= div_tick; // [RULE6]
      baud_q   <= cfg.sync_mode ? div_tick : os_tick; // [RULE11] [RULE6]
    end
  end

  assign sample_tick = sample_q;
  assign baud_tick   = baud_q;

  // ********************************************************************
  // serial clock output
  // ********************************************************************
  // high for the first half of each divider period; a falling-edge copy
  // adds the missing half cycle when master_clock is divided by odd
  always_ff @(posedge mclk) begin
    if (rst || cfg.clock_divisor <= DIV_BYPASS) begin
      hi_q <= 1'b0;
    end else begin
      hi_q <= (cnt_d < {1'b0, cfg.clock_divisor[15:1]});
    end
  end

  always_ff @(negedge mclk) begin
    if (rst) begin
      hi_n_q <= 1'b0;
    end else begin
      hi_n_q <= hi_q;
    end
  end

  assign odd_fix = (cfg.divider_source_select == SRC_MCLK) &
                   cfg.clock_divisor[0]; // [RULE13]
  assign sck_out = hi_q | (odd_fix & hi_n_q); // [RULE13]
  assign sck_oe  = cfg.sync_mode &
                   (cfg.divider_source_select != SRC_EXT);

  // ********************************************************************
  // checking helpers
  // ********************************************************************
  baud_cfg_t   cfg_q;
  logic        seen_q;
  logic [15:0] gap_q;
  logic [4:0]  since_q;
  logic [15:0] hicnt_q;
  logic        steady;

  assign steady = (cfg == cfg_q) & seen_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q   <= '0;
      seen_q  <= 1'b0;
      gap_q   <= 16'h0000;
      since_q <= 5'h00;
      hicnt_q <= 16'h0000;
    end else begin
      cfg_q   <= cfg;
      seen_q  <= (cfg != cfg_q) ? 1'b0 : (seen_q | baud_q);
      gap_q   <= sample_q ? 16'h0000 : gap_q + 16'h0001;
      since_q <= baud_q ? 5'h00 : since_q + {4'h0, sample_q};
      hicnt_q <= hi_q ? hicnt_q + 16'h0001 : 16'h0000;
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  a_zero_div_silent: assert property ( // [RULE3]
    @(posedge mclk) disable iff (rst)
    (cfg.clock_divisor == DIV_OFF && !ext_direct)[*2] |->
    (!sample_q && !baud_q))
    else $error("ticks with divisor zero");

  a_bypass_pass: assert property ( // [RULE4]
    @(posedge mclk) disable iff (rst)
    (cfg.clock_divisor == DIV_BYPASS && !ext_direct &&
     cfg.divider_source_select == SRC_MCLK) |=> sample_q)
    else $error("bypass did not pass master clock");

  a_prescale_rate: assert property ( // [RULE1]
    @(posedge mclk) disable iff (rst)
    pre_tick |-> ##1 !pre_tick[*7] ##1 pre_tick)
    else $error("prescaler not divide by eight");

  a_sample_period: assert property ( // [RULE2]
    @(posedge mclk) disable iff (rst)
    (sample_q && steady && cfg.divider_source_select == SRC_MCLK &&
     cfg.clock_divisor > DIV_BYPASS) |->
    (gap_q == cfg.clock_divisor - DIV_ONE ||
     (frac_on && gap_q == cfg.clock_divisor))) // [RULE9] [RULE10]
    else $error("sampling period wrong");

  a_oversample_ratio: assert property ( // [RULE7]
    @(posedge mclk) disable iff (rst)
    (baud_q && steady && !cfg.sync_mode) |->
    (since_q == {1'b0, os_last})) // [RULE6] [RULE8]
    else $error("oversampling ratio wrong");

  a_sync_no_os: assert property ( // [RULE11]
    @(posedge mclk) disable iff (rst)
    (cfg.sync_mode && $stable(cfg.sync_mode)) |-> (baud_q == sample_q))
    else $error("sync baud differs from divider");

  a_ext_direct: assert property ( // [RULE12]
    @(posedge mclk) disable iff (rst)
    (ext_direct && ext_tick) |=> baud_q ##1 !baud_q)
    else $error("external edge not a bit clock");

  // the count already includes the last high cycle when hi_q falls
  a_sck_duty: assert property ( // [RULE13]
    @(posedge mclk) disable iff (rst)
    ($fell(hi_q) && steady && cfg.sync_mode &&
     cfg.divider_source_select == SRC_MCLK) |->
    (hicnt_q == {1'b0, cfg.clock_divisor[15:1]}))
    else $error("serial clock high phase wrong");

  a_ext_pulse: assert property ( // [RULE16]
    @(posedge mclk) disable iff (rst)
    ext_tick |-> ($rose(chk_q) && sync_q) ##1 !ext_tick)
    else $error("external tick without a filtered pin rise");

  c_async16: cover property (@(posedge mclk) disable iff (rst)
    baud_q && steady && !cfg.sync_mode && !cfg.over8);
  c_async8: cover property (@(posedge mclk) disable iff (rst)
    baud_q && steady && !cfg.sync_mode && cfg.over8);
  c_frac_long: cover property (@(posedge mclk) disable iff (rst)
    sample_q && frac_on && gap_q == cfg.clock_divisor);
  c_ext_sync: cover property (@(posedge mclk) disable iff (rst)
    baud_q && ext_direct);

endmodule

// ==== ext_sck_source.sv ====
// behavioural external clock source for the serial clock pin
`timescale 1ns/1ps
module ext_sck_source #(
  parameter real HALF_NS = 250.0 // half period, 5 master periods
) (
  input  wire logic en,  // run the clock
  output logic      sck  // pin level driven by the far side
);
  // pin stands still low outside the run window
  initial begin
    sck = 1'b0;
    forever begin
      wait (en);
      #(HALF_NS) sck = 1'b1;
      #(HALF_NS) sck = 1'b0;
    end
  end
endmodule

// ==== usart_baud_rate_generator_bench.sv ====
// self-checking bench for the baud rate generator
`timescale 1ns/1ps
module usart_baud_rate_generator_bench;
  import baud_pkg::*;
  logic      mclk;
  logic      rst;
  baud_cfg_t cfg;
  logic      sck_in;
  logic      sample_tick;
  logic      baud_tick;
  logic      sck_out;
  logic      sck_oe;
  logic      ext_en;
  logic      ext_sck;
  int        err_count;
  int        tests_run;
  int        n;
  realtime   t0;

  // pin level: whoever holds the drive enable wins
  assign sck_in = sck_oe ? sck_out : ext_sck;

  baud_gen baud_gen_i (.mclk(mclk), .rst(rst), .cfg(cfg), .sck_in(sck_in),
    .sample_tick(sample_tick), .baud_tick(baud_tick), .sck_out(sck_out),
    .sck_oe(sck_oe));
  ext_sck_source ext_sck_source_i (.en(ext_en), .sck(ext_sck));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task check(input string what, input int exp, input int got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task set_cfg(input logic [1:0] src, input logic sy, input logic ov,
               input logic nm, input logic [15:0] cd, input logic [2:0] fp);
    @(posedge mclk);
    #1;
    cfg = '{src, sy, ov, nm, cd, fp};
    ext_en = (src == SRC_EXT);
  endtask

  // cycles until the next pulse; bounded so a dead divider cannot hang
  task wait_tick(input bit b, output int k);
    for (k = 1; k < 3000; k++) begin
      @(posedge mclk);
      #1;
      if ((b ? baud_tick : sample_tick) === 1'b1) break;
    end
  endtask

  task run_case(input string nm, input logic [1:0] src, input logic sy,
                input logic ov, input logic [15:0] cd, input int es,
                input int eb);
    set_cfg(src, sy, ov, 1'b1, cd, 3'h0);
    wait_tick(1'b0, n);
    wait_tick(1'b0, n);
    wait_tick(1'b0, n);
    check({nm, " sample gap"}, es, n);
    wait_tick(1'b1, n);
    wait_tick(1'b1, n);
    check({nm, " baud gap"}, eb, n);
    check_bit({nm, " sample at baud"}, 1'b1, sample_tick);
    $display("test %s done", nm);
  endtask

  initial begin
    #400_000;
    err_count++;
    $display("Error watchdog expected done seen hang");
    conclude();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    ext_en = 1'b0;
    cfg = '{SRC_MCLK, 1'b0, 1'b0, 1'b1, DIV_OFF, 3'h0};
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    run_case("async x8", SRC_MCLK, 1'b0, 1'b1, 16'h0003, 3, 24);
    run_case("async x16", SRC_MCLK, 1'b0, 1'b0, 16'h0003,
             3, 48);
    run_case("div source", SRC_MCLK_DIV, 1'b0, 1'b1, 16'h0002,
             16, 128);
    run_case("bypass", SRC_MCLK, 1'b1, 1'b0, DIV_BYPASS, 1, 1);
    run_case("sync", SRC_MCLK, 1'b1, 1'b0, 16'h0005, 5, 5);
    run_case("sync ext", SRC_EXT, 1'b1, 1'b0, 16'h0000, 10, 10);
    check_bit("sck_oe ext", 1'b0, sck_oe);
    run_case("async ext", SRC_EXT, 1'b0, 1'b1, 16'h0002, 20, 160);
    // zero divisor: count every pulse over a long window
    set_cfg(SRC_MCLK, 1'b0, 1'b1, 1'b1, DIV_OFF, 3'h0);
    repeat (4) @(posedge mclk);
    n = 0;
    repeat (300) begin
      @(posedge mclk);
      #1;
      n += (sample_tick !== 1'b0) + (baud_tick !== 1'b0);
    end
    check("ticks at cd 0", 0, n);
    $display("test zero divisor done");
    // fraction: eight sample periods must total 8*cd + fp cycles in normal mode, 8*cd otherwise
    for (int m = 1; m >= 0; m--) begin
      set_cfg(SRC_MCLK, 1'b0, 1'b1, m[0], 16'h0002, 3'h4);
      wait_tick(1'b0, n);
      wait_tick(1'b0, n);
      t0 = 0;
      repeat (8) begin
        wait_tick(1'b0, n);
        t0 += n;
      end
      check("eight periods", m ? 20 : 16, int'(t0));
    end
    $display("test fraction done");
    // odd divisor still gives half-period high time on master source
    for (int c = 4; c <= 5; c++) begin
      set_cfg(SRC_MCLK, 1'b1, 1'b0, 1'b1, c[15:0], 3'h0);
      @(posedge sck_out);
      @(posedge sck_out);
      t0 = $realtime;
      @(negedge sck_out);
      check("sck high ns", c * 25, int'($realtime - t0));
      check_bit("sck_oe sync", 1'b1, sck_oe);
    end
    // divided source: software keeps the divisor even for an even split
    set_cfg(SRC_MCLK_DIV, 1'b1, 1'b0, 1'b1, 16'h0002, 3'h0);
    @(posedge sck_out);
    @(posedge sck_out);
    t0 = $realtime;
    @(negedge sck_out);
    check("sck div high ns", 400, int'($realtime - t0));
    t0 = $realtime;
    @(posedge sck_out);
    check("sck div low ns", 400, int'($realtime - t0));
    $display("test duty cycle done");
    conclude();
  end
endmodule
